// ===== hdl/pee_pkg.sv
// package: constants and carriers for the paged eeprom host port
package pee_pkg;
    localparam int CLK_PERIOD_NS = 100;
    // printed times in their own units
    localparam int T_WP_NS       = 150;   // write pulse low, least
    localparam int T_WPH_NS      = 100;   // write pulse high, least
    localparam int T_ACC_NS      = 250;   // address/enable to data, most
    localparam int T_OEHP_NS     = 150;   // output enable high between polls, least
    localparam int T_BLC_US      = 150;   // byte load window, most
    localparam int T_WC_MS       = 10;    // write cycle, most
    localparam int T_PWR_MS      = 5;     // power-on write delay
    // cycle counts: least times and the access time round up, the long times round down
    localparam int WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WPH_CYC  = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC  = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OEHP_CYC = (T_OEHP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLC_CYC  = (T_BLC_US * 1000) / CLK_PERIOD_NS;
    localparam int WC_CYC   = (T_WC_MS * 1000000) / CLK_PERIOD_NS;
    localparam int PWR_CYC  = (T_PWR_MS * 1000000) / CLK_PERIOD_NS;
    // own gap limit, half the window, leaves room for pin latency
    localparam int GAP_CYC  = BLC_CYC / 2;
    // synchroniser depth plus the output register lag
    localparam int SYNC_CYC = 4;
    localparam int CNT_W    = 20;
    // address layout
    localparam int ADDR_W    = 17;
    localparam int DATA_W    = 8;
    localparam int PAGE_LSB  = 6;
    localparam int POLL_BIT  = 7;
    localparam int TOGG_BIT  = 6;
    localparam int SEQ_LEN   = 3;

    typedef enum logic [1:0] {
        PEE_OP_READ,
        PEE_OP_LOAD,
        PEE_OP_PROT_ON,
        PEE_OP_PROT_OFF
    } pee_op_t;

    typedef struct packed {
        pee_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
        logic                last;   // close the page after this load
    } pee_cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0]   data;
        logic                err;    // programming did not end in time
    } pee_rsp_t;
endpackage

// ===== hdl/pee_host.sv
// host controller driving a paged eeprom through its parallel pins
`timescale 1ns/1ps

module pee_host #(
    parameter int                                           WC_CYC  = pee_pkg::WC_CYC,
    parameter int                                           PWR_CYC = pee_pkg::PWR_CYC,
    parameter logic [2:0][pee_pkg::ADDR_W-1:0]              SDP_ON_ADDR  = {17'h00003, 17'h00002, 17'h00001},
    parameter logic [2:0][pee_pkg::DATA_W-1:0]              SDP_ON_DATA  = {8'h03, 8'h02, 8'h01},
    parameter logic [2:0][pee_pkg::ADDR_W-1:0]              SDP_OFF_ADDR = {17'h00006, 17'h00005, 17'h00004},
    parameter logic [2:0][pee_pkg::DATA_W-1:0]              SDP_OFF_DATA = {8'h06, 8'h05, 8'h04}
) (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    // user command side
    input  wire logic                        cmd_valid,
    output logic                             cmd_ready,
    input  wire pee_pkg::pee_cmd_t           cmd,
    output logic                             rsp_valid,
    output pee_pkg::pee_rsp_t                rsp,
    output logic                             prot_on,
    // memory pins
    output logic [pee_pkg::ADDR_W-1:0]       byte_address,
    output logic                             mem_ce_n,
    output logic                             mem_oe_n,
    output logic                             mem_we_n,
    output logic [pee_pkg::DATA_W-1:0]       data_lines_o,
    output logic                             data_lines_oe_n,
    input  wire logic [pee_pkg::DATA_W-1:0]  data_lines_i
);
    typedef enum logic [3:0] {
        S_PWR, S_IDLE, S_WSET, S_WLOW, S_WHIGH, S_RLOW, S_PLOW, S_PHIGH
    } pee_state_t;

    localparam logic [pee_pkg::CNT_W-1:0] C_WP   = pee_pkg::CNT_W'(pee_pkg::WP_CYC);
    localparam logic [pee_pkg::CNT_W-1:0] C_WPH  = pee_pkg::CNT_W'(pee_pkg::WPH_CYC);
    localparam logic [pee_pkg::CNT_W-1:0] C_RD   =
        pee_pkg::CNT_W'(pee_pkg::ACC_CYC + pee_pkg::SYNC_CYC);
    localparam logic [pee_pkg::CNT_W-1:0] C_OEHP = pee_pkg::CNT_W'(pee_pkg::OEHP_CYC);
    localparam logic [pee_pkg::CNT_W-1:0] C_GAP  = pee_pkg::CNT_W'(pee_pkg::GAP_CYC);
    localparam logic [pee_pkg::CNT_W-1:0] C_WC   = pee_pkg::CNT_W'(WC_CYC);
    localparam logic [pee_pkg::CNT_W-1:0] C_PWR  = pee_pkg::CNT_W'(PWR_CYC);

    pee_state_t                       st_q;
    logic [pee_pkg::CNT_W-1:0]        cnt_q;
    logic [pee_pkg::CNT_W-1:0]        wc_q;
    pee_pkg::pee_cmd_t                cur_q;
    logic [1:0]                       seq_q;
    logic                             in_page_q;
    logic                             sdp_q;
    logic [pee_pkg::ADDR_W-1:0]       last_addr_q;
    logic [pee_pkg::DATA_W-1:0]       last_data_q;
    logic                             prev6_q;
    logic                             polled_q;
    logic [pee_pkg::DATA_W-1:0]       s1_q;
    logic [pee_pkg::DATA_W-1:0]       s2_q;
    logic [pee_pkg::DATA_W-1:0]       s3_q;

    // three-stage pin synchroniser; only stages two and three are compared
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            s3_q <= 8'h00;
        end
        else
        begin
            s1_q <= data_lines_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // decode of what the current bus cycle drives
    wire                          in_seq    = (seq_q != 2'd3);
    wire                          off_op    = (cur_q.op == pee_pkg::PEE_OP_PROT_OFF);
    wire [pee_pkg::ADDR_W-1:0]    seq_addr  = off_op ? SDP_OFF_ADDR[seq_q] : SDP_ON_ADDR[seq_q];
    wire [pee_pkg::DATA_W-1:0]    seq_data  = off_op ? SDP_OFF_DATA[seq_q] : SDP_ON_DATA[seq_q];
    wire [pee_pkg::ADDR_W-1:0]    wr_addr   = in_seq ? seq_addr : cur_q.addr;
    wire [pee_pkg::DATA_W-1:0]    wr_data   = in_seq ? seq_data : cur_q.data;
    wire                          rd_stable = (s2_q == s3_q);
    localparam int PAGE_LSB_W = pee_pkg::PAGE_LSB;
    // a new load must share the open page, else the page closes first
    wire                          same_page = (cmd.addr[pee_pkg::ADDR_W-1:PAGE_LSB_W] ==
                                               last_addr_q[pee_pkg::ADDR_W-1:PAGE_LSB_W]);
    wire                          fits_page = (cmd.op == pee_pkg::PEE_OP_LOAD) && same_page;
    wire                          close_pg  = in_page_q && ((cmd_valid && !fits_page) ||
                                              (cnt_q >= C_GAP));
    wire                          take      = cmd_valid && cmd_ready;
    // command cycles store no byte, so only the toggle bit can end their poll
    wire                          bit7_ok   = (cur_q.op != pee_pkg::PEE_OP_LOAD) ||
                                              (s3_q[pee_pkg::POLL_BIT] ==
                                               last_data_q[pee_pkg::POLL_BIT]);
    // poll result: true bit 7 and bit 6 steady over two reads
    wire                          poll_done = bit7_ok && polled_q &&
                                              (s3_q[pee_pkg::TOGG_BIT] == prev6_q);

    assign cmd_ready = (st_q == S_IDLE) && !close_pg;
    assign prot_on   = sdp_q;

    // main sequencer
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q        <= S_PWR;
            cnt_q       <= '0;
            wc_q        <= '0;
            cur_q       <= '0;
            seq_q       <= 2'd3;
            in_page_q   <= 1'b0;
            sdp_q       <= 1'b0;     // delivered unprotected; a host reset assumes that
            last_addr_q <= '0;
            last_data_q <= 8'h00;
            prev6_q     <= 1'b0;
            polled_q    <= 1'b0;
            rsp_valid   <= 1'b0;
            rsp         <= '0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            cnt_q     <= cnt_q + 1'b1;
            case (st_q)
                S_PWR:
                begin
                    if (cnt_q >= C_PWR)
                    begin
                        st_q  <= S_IDLE;
                        cnt_q <= '0;
                    end
                end
                S_IDLE:
                begin
                    if (close_pg)
                    begin
                        // device starts programming on its own at the window end
                        st_q     <= S_PLOW;
                        cnt_q    <= '0;
                        wc_q     <= '0;
                        polled_q <= 1'b0;
                    end
                    else if (take)
                    begin
                        cur_q <= cmd;
                        cnt_q <= '0;
                        if (cmd.op == pee_pkg::PEE_OP_READ)
                            st_q <= S_RLOW;
                        else
                        begin
                            st_q <= S_WSET;
                            // prefix only at the start of a write cycle
                            seq_q <= (cmd.op != pee_pkg::PEE_OP_LOAD ||
                                      (sdp_q && !in_page_q)) ? 2'd0 : 2'd3;
                        end
                    end
                end
                S_WSET:
                begin
                    // address settles with chip enable before the strobe falls
                    st_q  <= S_WLOW;
                    cnt_q <= '0;
                end
                S_WLOW:
                begin
                    if (cnt_q >= C_WP - 1'b1)
                    begin
                        st_q  <= S_WHIGH;
                        cnt_q <= '0;
                    end
                end
                S_WHIGH:
                begin
                    if (cnt_q >= C_WPH - 1'b1)
                    begin
                        cnt_q       <= '0;
                        last_addr_q <= wr_addr;
                        last_data_q <= wr_data;
                        if (seq_q < 2'd2)
                        begin
                            seq_q <= seq_q + 2'd1;
                            st_q  <= S_WSET;
                        end
                        else if (seq_q == 2'd2 && cur_q.op == pee_pkg::PEE_OP_LOAD)
                        begin
                            seq_q <= 2'd3;
                            st_q  <= S_WSET;
                        end
                        else if (cur_q.op == pee_pkg::PEE_OP_LOAD && !cur_q.last)
                        begin
                            // page stays open; any order, reloads allowed
                            in_page_q <= 1'b1;
                            st_q      <= S_IDLE;
                        end
                        else
                        begin
                            if (cur_q.op == pee_pkg::PEE_OP_PROT_ON)
                                sdp_q <= 1'b1;
                            if (cur_q.op == pee_pkg::PEE_OP_PROT_OFF)
                                sdp_q <= 1'b0;
                            seq_q     <= 2'd3;
                            in_page_q <= 1'b1;
                            st_q      <= S_PLOW;
                            wc_q      <= '0;
                            polled_q  <= 1'b0;
                        end
                    end
                end
                S_RLOW:
                begin
                    if (cnt_q >= C_RD && rd_stable)
                    begin
                        rsp_valid <= 1'b1;
                        rsp.data  <= s3_q;
                        rsp.err   <= 1'b0;
                        st_q      <= S_IDLE;
                        cnt_q     <= '0;
                    end
                end
                S_PLOW:
                begin
                    wc_q <= wc_q + 1'b1;
                    if (cnt_q >= C_RD && rd_stable)
                    begin
                        prev6_q  <= s3_q[pee_pkg::TOGG_BIT];
                        polled_q <= 1'b1;
                        cnt_q    <= '0;
                        if (poll_done || wc_q >= C_WC)
                        begin
                            rsp_valid <= 1'b1;
                            rsp.data  <= s3_q;
                            rsp.err   <= !poll_done;
                            in_page_q <= 1'b0;
                            st_q      <= S_IDLE;
                        end
                        else
                            st_q <= S_PHIGH;
                    end
                end
                S_PHIGH:
                begin
                    wc_q <= wc_q + 1'b1;
                    if (cnt_q >= C_OEHP - 1'b1)
                    begin
                        st_q  <= S_PLOW;
                        cnt_q <= '0;
                    end
                end
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end

    // pin decode from state; registered so the strobes never glitch
    wire wr_cyc = (st_q == S_WSET) || (st_q == S_WLOW) || (st_q == S_WHIGH);
    wire rd_cyc = (st_q == S_RLOW) || (st_q == S_PLOW);

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            byte_address    <= '0;
            mem_ce_n        <= 1'b1;
            mem_oe_n        <= 1'b1;
            mem_we_n        <= 1'b1;
            data_lines_o    <= 8'h00;
            data_lines_oe_n <= 1'b1;
        end
        else
        begin
            byte_address    <= wr_cyc ? wr_addr :
                               (st_q == S_RLOW ? cur_q.addr : last_addr_q);
            mem_ce_n        <= !(wr_cyc || rd_cyc || st_q == S_PHIGH);
            mem_oe_n        <= !rd_cyc;                 // high in writes
            mem_we_n        <= (st_q != S_WLOW);
            data_lines_o    <= wr_data;
            data_lines_oe_n <= !wr_cyc;                 // released no later than the edge that starts any read
        end
    end
endmodule

// ===== verification/pee_host_checker.sv
// pin and answer assertions for the paged eeprom host controller
`timescale 1ns/1ps
module pee_host_checker #(
    parameter int PWR_CYC = 10
) (
    // clock and reset
    input wire logic                         sys_clk,
    input wire logic                         sys_rst,
    // user side
    input wire logic                         cmd_ready,
    input wire logic                         rsp_valid,
    input wire pee_pkg::pee_rsp_t            rsp,
    // memory pins
    input wire logic [pee_pkg::ADDR_W-1:0]   byte_address,
    input wire logic                         mem_ce_n,
    input wire logic                         mem_oe_n,
    input wire logic                         mem_we_n,
    input wire logic [pee_pkg::DATA_W-1:0]   data_lines_o,
    input wire logic                         data_lines_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    int pw_cnt;

    // cycles since reset release, saturating at the power-on window
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst) pw_cnt <= 0;
        else if (pw_cnt < PWR_CYC) pw_cnt <= pw_cnt + 1;
    end

    a_read_clean: assert property (!mem_oe_n |-> mem_we_n && !mem_ce_n && data_lines_oe_n)
        else $error("read cycle with strobe low or host driving");
    a_write_shape: assert property (!mem_we_n |-> mem_oe_n && !mem_ce_n && !data_lines_oe_n)
        else $error("write strobe low outside a proper write");
    a_pulse_width: assert property ($fell(mem_we_n) |=> !mem_we_n)
        else $error("write strobe low pulse too short");
    a_addr_hold: assert property (!mem_we_n && !$fell(mem_we_n) |-> $stable(byte_address))
        else $error("address moved during strobe low");
    a_data_hold: assert property ($rose(mem_we_n) |-> !data_lines_oe_n && $stable(data_lines_o))
        else $error("write data not held to strobe rise");
    a_oe_gap: assert property ($rose(mem_oe_n) && !mem_ce_n |=> mem_oe_n)
        else $error("output enable high gap too short");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer strobe longer than one cycle");
    a_rsp_hold: assert property (!rsp_valid |-> $stable(rsp))
        else $error("answer changed without strobe");
    a_power_wait: assert property (pw_cnt < PWR_CYC |-> !cmd_ready)
        else $error("command accepted inside power-on delay");

    c_timeout: cover property (rsp_valid && rsp.err);
    c_write: cover property ($rose(mem_we_n));
    c_poll: cover property ($fell(mem_oe_n));
endmodule

bind pee_host pee_host_checker #(.PWR_CYC(PWR_CYC)) i_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .byte_address(byte_address), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .data_lines_o(data_lines_o), .data_lines_oe_n(data_lines_oe_n));

// ===== verification/pee_mem_model.sv
// behavioural paged eeprom answering the host pins
`timescale 1ns/1ps
module pee_mem_model #(
    parameter int               PWR_CYC = 10,
    parameter logic [2:0][16:0] ON_A    = '0,
    parameter logic [2:0][7:0]  ON_D    = '0,
    parameter logic [2:0][16:0] OFF_A   = '0,
    parameter logic [2:0][7:0]  OFF_D   = '0
) (
    // sampling clock and programming time
    input wire logic        sys_clk,
    input wire logic [31:0] prog_len,
    // memory pins
    input wire logic [16:0] byte_address,
    input wire logic        mem_ce_n,
    input wire logic        mem_oe_n,
    input wire logic        mem_we_n,
    input wire logic [7:0]  data_lines_o,
    input wire logic        data_lines_oe_n,
    output logic [7:0]      data_lines_i
);
    logic [7:0] mem [int];
    logic [7:0] pg [int];
    logic [16:0] adr_l = '0;
    logic [7:0] last_d = '0, cur = '0, drv = 8'h5a;
    logic we_q = 1'b1, oe_q = 1'b1, tog = 1'b0, prot = 1'b0, unlock = 1'b0, open_q = 1'b0;
    int ld_cnt = 0, prg_cnt = 0, pw_cnt = 0, on_i = 0, off_i = 0;
    wire rd = !mem_ce_n && !mem_oe_n && mem_we_n;
    wire busy = open_q || prg_cnt != 0;
    assign data_lines_i = drv;

    function automatic logic [7:0] peek(input int a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction

    // one byte into the page buffer unless it belongs to a protection command, or protection is on with no unlock prefix
    task automatic load(input logic [16:0] a, input logic [7:0] d);
        bit hit;
        hit = (a == ON_A[on_i] && d == ON_D[on_i]) || (a == OFF_A[off_i] && d == OFF_D[off_i]);
        on_i = (a == ON_A[on_i] && d == ON_D[on_i]) ? on_i + 1 : 0;
        off_i = (a == OFF_A[off_i] && d == OFF_D[off_i]) ? off_i + 1 : 0;
        if (on_i == 3)
        begin
            prot = 1'b1; // not cleared by any host reset
            unlock = 1'b1;
            on_i = 0;
        end
        if (off_i == 3)
        begin
            prot = 1'b0;
            off_i = 0;
        end
        if (!hit && (!prot || unlock)) pg[a] = d; // latest value wins
        last_d = d;
        open_q = 1'b1;
        ld_cnt = 0;
    endtask

    // pins looked at once a cycle, so shorter pulses never count
    always @(posedge sys_clk)
    begin
        if (pw_cnt < PWR_CYC) pw_cnt++;
        if (!mem_ce_n && we_q && !mem_we_n) adr_l = byte_address;
        if (!mem_ce_n && mem_oe_n && !we_q && mem_we_n && pw_cnt >= PWR_CYC && prg_cnt == 0)
            load(adr_l, data_lines_oe_n ? 8'hxx : data_lines_o);
        else if (open_q && ld_cnt < pee_pkg::BLC_CYC)
            ld_cnt++;
        else if (open_q)
        begin
            foreach (pg[k]) mem[k] = pg[k];
            pg.delete();
            open_q = 1'b0;
            unlock = 1'b0;
            prg_cnt = prog_len;
        end
        else if (prg_cnt != 0)
            prg_cnt--;
        if (rd && oe_q && busy) tog = !tog;
        cur = peek(byte_address);
        if (!rd) drv <= ~drv; // released lines never keep the last byte
        else if (busy) drv <= {~last_d[7], tog, cur[5:0]};
        else drv <= cur;
        we_q = mem_we_n;
        oe_q = mem_oe_n;
    end
endmodule

// ===== verification/pee_host_bench.sv
// self-checking bench for the paged eeprom host controller
`timescale 1ns/1ps
module pee_host_bench;
    localparam int WC = 2000;
    localparam int PWR = 10;
    localparam logic [2:0][16:0] ON_A = {17'h0a3, 17'h0a2, 17'h0a1};
    localparam logic [2:0][7:0] ON_D = {8'h3c, 8'h5b, 8'ha7};
    localparam logic [2:0][16:0] OFF_A = {17'h0b3, 17'h0b2, 17'h0b1};
    localparam logic [2:0][7:0] OFF_D = {8'h1e, 8'h2d, 8'h4b};
    typedef struct { logic [7:0] d; logic e; bit cd; } pee_exp_t;
    logic sys_clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0;
    logic cmd_ready, rsp_valid, prot_on, ce_n, oe_n, we_n, dq_oe_n;
    logic [16:0] adr;
    logic [7:0] dq_o, dq_i;
    pee_pkg::pee_cmd_t cmd = '0;
    pee_pkg::pee_rsp_t rsp;
    int prog_len = 100, error_cnt = 0, n_compared = 0, cyc = 0, seed = 32'h6772;
    logic [7:0] shadow [int];
    pee_exp_t exp_q [$];
    pee_exp_t e;

    pee_host #(.WC_CYC(WC), .PWR_CYC(PWR), .SDP_ON_ADDR(ON_A), .SDP_ON_DATA(ON_D),
        .SDP_OFF_ADDR(OFF_A), .SDP_OFF_DATA(OFF_D)) i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .prot_on(prot_on), .byte_address(adr),
        .mem_ce_n(ce_n), .mem_oe_n(oe_n), .mem_we_n(we_n), .data_lines_o(dq_o),
        .data_lines_oe_n(dq_oe_n), .data_lines_i(dq_i));
    pee_mem_model #(.PWR_CYC(PWR), .ON_A(ON_A), .ON_D(ON_D), .OFF_A(OFF_A), .OFF_D(OFF_D))
        i_mem (.sys_clk(sys_clk), .prog_len(prog_len), .byte_address(adr), .mem_ce_n(ce_n),
        .mem_oe_n(oe_n), .mem_we_n(we_n), .data_lines_o(dq_o), .data_lines_oe_n(dq_oe_n),
        .data_lines_i(dq_i));

    always #50 sys_clk = ~sys_clk;

    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        n_compared++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic [7:0] peek(input int a);
        return shadow.exists(a) ? shadow[a] : 8'hff;
    endfunction

    // offer one command and hold it until the edge that takes it
    task automatic issue(input pee_pkg::pee_op_t op, input logic [16:0] a, input logic [7:0] d,
        input logic l);
        @(posedge sys_clk);
        #1;
        cmd = '{op, a, d, l};
        cmd_valid = 1'b1;
        #1;
        while (cmd_ready !== 1'b1)
        begin
            @(posedge sys_clk);
            #2;
        end
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
    endtask

    task automatic wr(input logic [16:0] a, input logic [7:0] d, input logic l);
        shadow[a] = d;
        if (l) exp_q.push_back('{d, 1'b0, 1'b1});
        issue(pee_pkg::PEE_OP_LOAD, a, d, l);
    endtask

    task automatic rd(input logic [16:0] a);
        exp_q.push_back('{peek(a), 1'b0, 1'b1});
        issue(pee_pkg::PEE_OP_READ, a, 8'h00, 1'b0);
    endtask

    task automatic drain();
        while (exp_q.size() != 0) @(posedge sys_clk);
    endtask

    // each answer takes the oldest note; data ignored where unknown to the bench
    always @(posedge sys_clk)
    begin
        if (!sys_rst && rsp_valid === 1'b1)
        begin
            if (exp_q.size() != 0)
                e = exp_q.pop_front();
            else
                e = '{8'hxx, 1'bx, 1'b1};
            check({e.cd ? rsp.data : e.d, rsp.err}, {e.d, e.e});
        end
    end

    // cuts a hang short
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    initial
    begin
        logic [16:0] a;
        a = '0;
        repeat (2) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        rd(17'h00123);
        wr(17'h00200, 8'($random(seed)), 1'b1);
        rd(17'h00200);
        // upper quadrant page in random order, one byte loaded twice
        for (int i = 0; i < 8; i++)
        begin
            if (i != 6) a = {11'h603, 6'($random(seed))};
            wr(a, 8'($random(seed)), i == 7);
        end
        for (int k = 0; k < 64; k++) rd({11'h603, 6'(k)});
        wr(17'h00a00, 8'h3c, 1'b0);
        exp_q.push_back('{8'h3c, 1'b0, 1'b1});
        wr(17'h00a40, 8'hc3, 1'b1);
        wr(17'h00b05, 8'($random(seed)), 1'b0);
        exp_q.push_back('{shadow[17'h00b05], 1'b0, 1'b1});
        drain();
        rd(17'h00b05);
        exp_q.push_back('{8'h00, 1'b0, 1'b0});
        issue(pee_pkg::PEE_OP_PROT_ON, 17'h00000, 8'h00, 1'b0);
        drain();
        check({8'h00, prot_on}, 9'h001);
        wr(17'h00c11, 8'h81, 1'b1);
        rd(17'h00c11);
        exp_q.push_back('{8'h00, 1'b0, 1'b0});
        issue(pee_pkg::PEE_OP_PROT_OFF, 17'h00000, 8'h00, 1'b0);
        drain();
        check({8'h00, prot_on}, 9'h000);
        // programming outlasting the host's wait ends in the error flag
        prog_len = 1000;
        shadow[17'h00d00] = 8'h55;
        exp_q.push_back('{8'h00, 1'b1, 1'b0});
        issue(pee_pkg::PEE_OP_LOAD, 17'h00d00, 8'h55, 1'b1);
        drain();
        prog_len = 100;
        repeat (1000) @(posedge sys_clk);
        rd(17'h00d00);
        drain();
        wrap_up();
    end
endmodule
